/* File: src/jisd_decoder.sv */
// Contract
// - Sample/preload captures pins, never updates outputs
// - Sample captures pins, shifts chain on TCK
// - Extest drives pins from latch from Update-DR
// - Extest captures pins, Update-DR drives pins
// - Intest feeds core from chain, drives pins
// - Intest captures core outputs, applies at updates
// - Clamp uses bypass, pins driven from chain
// - Bypass selects one-bit bypass register
// - Bypass register captures zero
// - Capture-IR loads p0001 or peb01
// - Debug opcode selects 34-bit service register
// - Direction bit one reads, zero writes
// - First scan is address, toggles when idle
// - Memory-service opcode selects 34-bit register
// - Update-DR between scans; read shows e,b,data; code puts b at bit 0, e at bit 1, data above
// - Instruction scan then idle then data scan
// - All patterns shift least significant first
// - Busy and error flags report bus state
// - Protected flag reports chip protection
`timescale 1ns/10ps
`default_nettype none
module jisd_decoder (
   input  wire logic                           clock,
   input  wire logic                           reset_n,
   input  wire logic                           tck,
   input  wire logic                           tms,
   input  wire logic                           tdi,
   output logic                                tdo,
   output logic                                tdoEn,
   input  wire logic                           chipProtected,
   input  wire logic [jisd_pkg::BS_LEN-1:0]    pinIn,
   output logic      [jisd_pkg::BS_LEN-1:0]    pinOut,
   output logic                                pinFromScan,
   input  wire logic [jisd_pkg::BS_LEN-1:0]    coreOut,
   output logic      [jisd_pkg::BS_LEN-1:0]    coreIn,
   output logic                                coreFromScan,
   output logic                                svcReq,
   output logic                                svcUnit,
   output logic                                svcRead,
   output logic      [jisd_pkg::ADDR_W-1:0]    svcAddr,
   output logic      [jisd_pkg::DATA_W-1:0]    svcWdata,
   input  wire logic                           svcAck,
   input  wire logic                           svcErr,
   input  wire logic [jisd_pkg::DATA_W-1:0]    svcRdata
);
   // ==========================================
   // Decode helpers
   function automatic logic isPriv(input logic [4:0] op);
      isPriv = (op == jisd_pkg::OP_DEBUG) || (op == jisd_pkg::OP_MEMSVC);
   endfunction

   function automatic logic isChain(input logic [4:0] op);
      isChain = (op == jisd_pkg::OP_SAMPLE) || (op == jisd_pkg::OP_EXTEST) || (op == jisd_pkg::OP_INTEST);
   endfunction

   function automatic jisd_pkg::jisd_tap_t tapNext(input jisd_pkg::jisd_tap_t s, input logic m);
      case (s)
         jisd_pkg::TLR:   tapNext = m ? jisd_pkg::TLR   : jisd_pkg::RTI;
         jisd_pkg::RTI:   tapNext = m ? jisd_pkg::SELDR : jisd_pkg::RTI;
         jisd_pkg::SELDR: tapNext = m ? jisd_pkg::SELIR : jisd_pkg::CAPDR;
         jisd_pkg::CAPDR: tapNext = m ? jisd_pkg::EX1DR : jisd_pkg::SHDR;
         jisd_pkg::SHDR:  tapNext = m ? jisd_pkg::EX1DR : jisd_pkg::SHDR;
         jisd_pkg::EX1DR: tapNext = m ? jisd_pkg::UPDDR : jisd_pkg::PAUDR;
         jisd_pkg::PAUDR: tapNext = m ? jisd_pkg::EX2DR : jisd_pkg::PAUDR;
         jisd_pkg::EX2DR: tapNext = m ? jisd_pkg::UPDDR : jisd_pkg::SHDR;
         jisd_pkg::UPDDR: tapNext = m ? jisd_pkg::SELDR : jisd_pkg::RTI;
         jisd_pkg::SELIR: tapNext = m ? jisd_pkg::TLR   : jisd_pkg::CAPIR;
         jisd_pkg::CAPIR: tapNext = m ? jisd_pkg::EX1IR : jisd_pkg::SHIR;
         jisd_pkg::SHIR:  tapNext = m ? jisd_pkg::EX1IR : jisd_pkg::SHIR;
         jisd_pkg::EX1IR: tapNext = m ? jisd_pkg::UPDIR : jisd_pkg::PAUIR;
         jisd_pkg::PAUIR: tapNext = m ? jisd_pkg::EX2IR : jisd_pkg::PAUIR;
         jisd_pkg::EX2IR: tapNext = m ? jisd_pkg::UPDIR : jisd_pkg::SHIR;
         jisd_pkg::UPDIR: tapNext = m ? jisd_pkg::SELDR : jisd_pkg::RTI;
         default:         tapNext = jisd_pkg::TLR;
      endcase
   endfunction

   // ==========================================
   // Pin synchronisers and TCK edge finder
   logic [2:0] s1_q, s2_q, s3_q;
   logic       tckF_q;
   always_ff @(posedge clock) begin
      if (!reset_n) begin
         s1_q   <= 3'h0;
         s2_q   <= 3'h0;
         s3_q   <= 3'h0;
         tckF_q <= 1'b0;
      end else begin
         s1_q <= {tck, tms, tdi};
         s2_q <= s1_q;
         s3_q <= s2_q;
         if (s2_q[2] == s3_q[2]) begin
            tckF_q <= s3_q[2];
         end
      end
   end
   wire agree = (s2_q[2] == s3_q[2]);
   wire rise  = agree && s3_q[2] && !tckF_q;
   wire fall  = agree && !s3_q[2] && tckF_q;
   wire tmsS  = s3_q[1];
   wire tdiS  = s3_q[0];

   // ==========================================
   // Controller state and decoded actions
   jisd_pkg::jisd_tap_t st_q;
   always_ff @(posedge clock) begin
      if (!reset_n) begin
         st_q <= jisd_pkg::TLR;
      end else if (rise) begin
         st_q <= tapNext(st_q, tmsS);
      end
   end

   logic [4:0] ir_q, irSh_q;
   wire priv     = isPriv(ir_q);
   wire chainSel = isChain(ir_q);
   wire bypSel   = !priv && !chainSel;
   wire capIr    = rise && (st_q == jisd_pkg::CAPIR);
   wire shIr     = rise && (st_q == jisd_pkg::SHIR);
   wire updIr    = rise && (st_q == jisd_pkg::UPDIR);
   wire capDr    = rise && (st_q == jisd_pkg::CAPDR);
   wire shDr     = rise && (st_q == jisd_pkg::SHDR);
   wire updDr    = rise && (st_q == jisd_pkg::UPDDR);
   wire tlr      = rise && (st_q == jisd_pkg::TLR);

   // ==========================================
   // Service bus bookkeeping
   logic                          pending_q, err_q, dataPhase_q, busyCap_q, dirRead_q, byp_q;
   logic [jisd_pkg::DATA_W-1:0]   rdata_q;
   logic [jisd_pkg::SVC_W-1:0]    svc_q;
   logic [jisd_pkg::BS_LEN-1:0]   bsc_q, bsUpd_q;
   localparam int                 SH_CNT_W = $clog2(jisd_pkg::SVC_W + 1);
   logic [SH_CNT_W-1:0]           shCnt_q;
   // Short address scans leave their bits at the top of the chain
   wire  [jisd_pkg::SVC_W-1:0]    svcAdr   = svc_q >> (jisd_pkg::SVC_W - 32'(shCnt_q));
   wire  advance  = updDr && priv && !busyCap_q;
   wire  issueRd  = advance && !dataPhase_q && svcAdr[jisd_pkg::SVC_R_BIT];
   wire  issueWr  = advance && dataPhase_q && !dirRead_q;
   wire  [4:0] irCap = isPriv(ir_q) ? {chipProtected, err_q, pending_q, jisd_pkg::IR_CAP_PRIV}
                                    : {chipProtected, jisd_pkg::IR_CAP_PUB};

   always_ff @(posedge clock) begin
      if (!reset_n) begin
         ir_q   <= jisd_pkg::IR_RESET;
         irSh_q <= jisd_pkg::IR_RESET;
      end else if (tlr) begin
         ir_q <= jisd_pkg::IR_RESET;
      end else if (capIr) begin
         irSh_q <= irCap;
      end else if (shIr) begin
         irSh_q <= {tdiS, irSh_q[4:1]};
      end else if (updIr) begin
         ir_q <= irSh_q;
      end
   end

   always_ff @(posedge clock) begin
      if (!reset_n) begin
         dataPhase_q <= 1'b0;
         dirRead_q   <= 1'b0;
         busyCap_q   <= 1'b0;
      end else if (updIr) begin
         dataPhase_q <= 1'b0;
      end else if (capDr && priv) begin
         busyCap_q <= pending_q;
      end else if (advance) begin
         dataPhase_q <= !dataPhase_q;
         if (!dataPhase_q) begin
            dirRead_q <= svcAdr[jisd_pkg::SVC_R_BIT];
         end
      end
   end

   // Set wins over clear so a late error is never lost
   always_ff @(posedge clock) begin
      if (!reset_n) begin
         pending_q <= 1'b0;
         err_q     <= 1'b0;
         rdata_q   <= '0;
      end else begin
         pending_q <= (issueRd || issueWr) || (pending_q && !svcAck);
         if (svcAck && svcErr) begin
            err_q <= 1'b1;
         end else if (capDr && priv) begin
            err_q <= 1'b0;
         end
         if (svcAck && dirRead_q) begin
            rdata_q <= svcRdata;
         end
      end
   end

   always_ff @(posedge clock) begin
      if (!reset_n) begin
         svcReq   <= 1'b0;
         svcUnit  <= 1'b0;
         svcRead  <= 1'b0;
         svcAddr  <= '0;
         svcWdata <= '0;
      end else begin
         svcReq <= issueRd || issueWr;
         if (advance && !dataPhase_q) begin
            svcUnit <= (ir_q == jisd_pkg::OP_MEMSVC);
            svcRead <= svcAdr[jisd_pkg::SVC_R_BIT];
            svcAddr <= svcAdr[jisd_pkg::SVC_A_LSB +: jisd_pkg::ADDR_W];
         end
         if (issueWr) begin
            svcWdata <= svc_q[jisd_pkg::SVC_D_LSB +: jisd_pkg::DATA_W];
         end
      end
   end

   // ==========================================
   // Data register chains
   always_ff @(posedge clock) begin
      if (!reset_n) begin
         svc_q   <= '0;
         byp_q   <= 1'b0;
         shCnt_q <= '0;
      end else if (capDr) begin
         svc_q   <= {rdata_q, err_q, pending_q};
         byp_q   <= 1'b0;
         shCnt_q <= '0;
      end else if (shDr) begin
         svc_q <= {tdiS, svc_q[jisd_pkg::SVC_W-1:1]};
         byp_q <= tdiS;
         if (shCnt_q != SH_CNT_W'(jisd_pkg::SVC_W)) begin
            shCnt_q <= shCnt_q + 1'b1;
         end
      end
   end

   always_ff @(posedge clock) begin
      if (!reset_n) begin
         bsc_q   <= '0;
         bsUpd_q <= '0;
      end else if (capDr && chainSel) begin
         bsc_q <= (ir_q == jisd_pkg::OP_INTEST) ? coreOut : pinIn;
      end else if (shDr && chainSel) begin
         bsc_q <= {tdiS, bsc_q[jisd_pkg::BS_LEN-1:1]};
      end else if (updDr && chainSel && (ir_q != jisd_pkg::OP_SAMPLE)) begin
         bsUpd_q <= bsc_q;
      end
   end

   // Latch drives pins and core, so one register feeds both at Update-DR
   logic pinScan_q, coreScan_q;
   always_ff @(posedge clock) begin
      if (!reset_n) begin
         pinScan_q  <= 1'b0;
         coreScan_q <= 1'b0;
      end else begin
         pinScan_q  <= (ir_q == jisd_pkg::OP_EXTEST) || (ir_q == jisd_pkg::OP_INTEST)
                       || (ir_q == jisd_pkg::OP_CLAMP);
         coreScan_q <= (ir_q == jisd_pkg::OP_INTEST);
      end
   end
   assign pinOut       = bsUpd_q;
   assign coreIn       = bsUpd_q;
   assign pinFromScan  = pinScan_q;
   assign coreFromScan = coreScan_q;

   // ==========================================
   // Test data out on falling TCK
   logic tdo_q, tdoEn_q;
   wire  drBit = priv ? svc_q[0] : (chainSel ? bsc_q[0] : byp_q);
   always_ff @(posedge clock) begin
      if (!reset_n) begin
         tdo_q   <= 1'b0;
         tdoEn_q <= 1'b0;
      end else if (fall) begin
         tdoEn_q <= (st_q == jisd_pkg::SHIR) || (st_q == jisd_pkg::SHDR);
         tdo_q   <= (st_q == jisd_pkg::SHIR) ? irSh_q[0] : drBit;
      end
   end
   assign tdo   = tdo_q;
   assign tdoEn = tdoEn_q;

   // ==========================================
   // Checks
   sequence sUpdPriv;
      updDr && priv;
   endsequence
   sequence sWrIssue;
      sUpdPriv ##0 (dataPhase_q && !busyCap_q && !dirRead_q);
   endsequence

   a_bypass_zero: assert property (@(posedge clock) disable iff (!reset_n)
      capDr |=> !byp_q) else $error("bypass bit not cleared at capture");
   a_ir_pub_cap: assert property (@(posedge clock) disable iff (!reset_n)
      (capIr && !priv) |=> irSh_q[3:0] == jisd_pkg::IR_CAP_PUB) else $error("bad public capture");
   a_ir_prot_flag: assert property (@(posedge clock) disable iff (!reset_n)
      capIr |=> irSh_q[jisd_pkg::IR_P_BIT] == $past(chipProtected)) else $error("protected flag wrong");
   a_sample_no_upd: assert property (@(posedge clock) disable iff (!reset_n)
      (updDr && ir_q == jisd_pkg::OP_SAMPLE) |=> $stable(bsUpd_q)) else $error("sample updated latch");
   a_extest_pins: assert property (@(posedge clock) disable iff (!reset_n)
      (ir_q == jisd_pkg::OP_EXTEST) ##1 (ir_q == jisd_pkg::OP_EXTEST) |-> pinScan_q && !coreScan_q)
      else $error("extest not driving pins");
   a_pin_capture: assert property (@(posedge clock) disable iff (!reset_n)
      (capDr && ir_q == jisd_pkg::OP_SAMPLE) |=> bsc_q == $past(pinIn)) else $error("pins not captured");
   a_phase_toggle: assert property (@(posedge clock) disable iff (!reset_n)
      (sUpdPriv ##0 !busyCap_q) |=> dataPhase_q != $past(dataPhase_q)) else $error("phase did not toggle");
   a_phase_hold: assert property (@(posedge clock) disable iff (!reset_n)
      (sUpdPriv ##0 busyCap_q) |=> $stable(dataPhase_q) && !svcReq) else $error("phase moved while busy");
   a_write_issue: assert property (@(posedge clock) disable iff (!reset_n)
      sWrIssue |=> svcReq && !svcRead ##1 !svcReq) else $error("write request wrong");
   a_bypass_out: assert property (@(posedge clock) disable iff (!reset_n)
      (fall && bypSel && st_q == jisd_pkg::SHDR) |=> tdoEn && (tdo == $past(byp_q)))
      else $error("bypass bit not on output");
endmodule
`default_nettype wire

/* File: src/jisd_pkg.sv */
package jisd_pkg;
   // ==========================================
   // Instruction register
   localparam int         IR_W        = 5;
   localparam logic [4:0] OP_SAMPLE   = 5'h02;
   localparam logic [4:0] OP_EXTEST   = 5'h03;
   localparam logic [4:0] OP_INTEST   = 5'h04;
   localparam logic [4:0] OP_CLAMP    = 5'h06;
   localparam logic [4:0] OP_DEBUG    = 5'h10;
   localparam logic [4:0] OP_MEMSVC   = 5'h14;
   localparam logic [4:0] OP_BYPASS   = 5'h1f;
   localparam logic [4:0] IR_RESET    = OP_BYPASS;
   localparam logic [3:0] IR_CAP_PUB  = 4'h1;
   localparam logic [1:0] IR_CAP_PRIV = 2'h1;
   localparam int         IR_P_BIT    = 4;
   localparam int         IR_E_BIT    = 3;
   localparam int         IR_B_BIT    = 2;
   // ==========================================
   // Data register chains
   localparam int BS_LEN    = 8;
   localparam int SVC_W     = 34;
   localparam int ADDR_W    = 7;
   localparam int DATA_W    = 32;
   localparam int SVC_R_BIT = 0;
   localparam int SVC_A_LSB = 1;
   localparam int SVC_B_BIT = 0;
   localparam int SVC_E_BIT = 1;
   localparam int SVC_D_LSB = 2;
   localparam int SYNC_N    = 3;
   // ==========================================
   // Test access port controller
   typedef enum logic [15:0] {
      TLR   = 16'h0001, RTI   = 16'h0002, SELDR = 16'h0004, CAPDR = 16'h0008,
      SHDR  = 16'h0010, EX1DR = 16'h0020, PAUDR = 16'h0040, EX2DR = 16'h0080,
      UPDDR = 16'h0100, SELIR = 16'h0200, CAPIR = 16'h0400, SHIR  = 16'h0800,
      EX1IR = 16'h1000, PAUIR = 16'h2000, EX2IR = 16'h4000, UPDIR = 16'h8000
   } jisd_tap_t;
endpackage

/* File: verif/jisd_probe.sv */
`timescale 1ns/10ps
`default_nettype none
module jisd_probe (
   input  wire logic clock,
   output logic      tck,
   output logic      tms,
   output logic      tdi,
   input  wire logic tdo
);
   // ==========================================
   // Tester side of the link
   initial begin
      tck = 1'b0;
      tms = 1'b1;
      tdi = 1'b0;
   end

   // Park TCK low so the last rising edge is seen and a reset finds no false edge
   task automatic rest();
      @(posedge clock);
      tck <= 1'b0;
      repeat (4) @(posedge clock);
   endtask

   // TCK is left high between calls; tdo is read late in the high half
   task automatic step(input logic m, input logic d, output logic o);
      @(posedge clock);
      tms <= m;
      tdi <= d;
      tck <= 1'b0;
      repeat (4) @(posedge clock);
      tck <= 1'b1;
      repeat (3) @(posedge clock);
      o = tdo;
   endtask

   // Idle to idle; tdi toggles outside shifting so no stale level hides
   task automatic scan(input logic ir, input int n, input logic [33:0] din,
                       output logic [33:0] dout);
      logic o;
      dout = '0;
      step(1'b1, ~tdi, o);
      if (ir) step(1'b1, ~tdi, o);
      step(1'b0, ~tdi, o);
      step(1'b0, ~tdi, o);
      for (int i = 0; i < n; i++) begin
         step(i == n - 1, din[i], o);
         dout[i] = o;
      end
      step(1'b1, ~tdi, o);
      step(1'b0, ~tdi, o);
      rest();
   endtask

   task automatic goIdle();
      logic o;
      repeat (5) step(1'b1, ~tdi, o);
      step(1'b0, ~tdi, o);
      rest();
   endtask
endmodule
`default_nettype wire

/* File: verif/testbench.sv */
`timescale 1ns/10ps
`default_nettype none
module testbench;
   // ==========================================
   // Signals
   localparam logic [31:0] RDATA = 32'h1234abcd;
   typedef struct packed {
      logic [4:0] op;
      logic       pfs;
      logic       cfs;
      logic [1:0] kind;
   } jisd_row_t;
   logic        clock, reset_n, tck, tms, tdi, tdo, tdoEn, chipProtected;
   logic        pinFromScan, coreFromScan, svcReq, svcUnit, svcRead;
   logic        svcAck, svcErr, ackErr;
   logic [7:0]  pinIn, pinOut, coreOut, coreIn, held;
   logic [6:0]  svcAddr;
   logic [31:0] svcWdata, svcRdata;
   logic [33:0] dout;
   logic [40:0] lastReq;
   int          err_total, comparisons, ackDelay, ackCnt, reqCount;
   // Kind: 0 bypass path, 1 pins, 2 core, 3 pins without update
   jisd_row_t   rows [6] = '{
      '{5'h02, 1'b0, 1'b0, 2'h3},
      '{5'h03, 1'b1, 1'b0, 2'h1},
      '{5'h04, 1'b1, 1'b1, 2'h2},
      '{5'h06, 1'b1, 1'b0, 2'h0},
      '{5'h1f, 1'b0, 1'b0, 2'h0},
      '{5'h0b, 1'b0, 1'b0, 2'h0}
   };

   initial begin
      clock = 1'b0;
      forever #50 clock = ~clock;
   end

   jisd_decoder dut_u (
      .clock(clock),
      .reset_n(reset_n),
      .tck(tck),
      .tms(tms),
      .tdi(tdi),
      .tdo(tdo),
      .tdoEn(tdoEn),
      .chipProtected(chipProtected),
      .pinIn(pinIn),
      .pinOut(pinOut),
      .pinFromScan(pinFromScan),
      .coreOut(coreOut),
      .coreIn(coreIn),
      .coreFromScan(coreFromScan),
      .svcReq(svcReq),
      .svcUnit(svcUnit),
      .svcRead(svcRead),
      .svcAddr(svcAddr),
      .svcWdata(svcWdata),
      .svcAck(svcAck),
      .svcErr(svcErr),
      .svcRdata(svcRdata)
   );

   jisd_probe prb_u (
      .clock(clock),
      .tck(tck),
      .tms(tms),
      .tdi(tdi),
      .tdo(tdo)
   );

   // ==========================================
   // Service bus responder; a long delay keeps the bus busy
   always @(posedge clock) begin
      if (!reset_n) begin
         svcAck <= 1'b0;
         svcErr <= 1'b0;
         svcRdata <= '0;
         ackCnt <= 0;
         reqCount <= 0;
      end else begin
         svcAck <= (ackCnt == 1);
         svcErr <= (ackCnt == 1) & ackErr;
         svcRdata <= (ackCnt == 1) ? RDATA : ~svcRdata;
         if (svcReq) begin
            ackCnt <= ackDelay;
            reqCount <= reqCount + 1;
            lastReq <= {svcUnit, svcRead, svcAddr, svcWdata};
         end else if (ackCnt > 0) begin
            ackCnt <= ackCnt - 1;
         end
      end
   end

   // ==========================================
   // Checking and verdict
   task automatic chk(input string nm, input logic [40:0] e, input logic [40:0] g);
      comparisons++;
      if (g !== e) begin
         err_total++;
         $display("[FAIL] %s expected %h seen %h", nm, e, g);
      end
   endtask

   task automatic final_report();
      $display("comparisons %0d err_total %0d", comparisons, err_total);
      if (err_total == 0 && comparisons > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask

   initial begin
      repeat (60000) @(posedge clock);
      err_total++;
      final_report();
   end

   // ==========================================
   // Main sequence
   initial begin
      reset_n = 1'b0;
      chipProtected = 1'b0;
      pinIn = 8'h00;
      coreOut = 8'h00;
      ackDelay = 5;
      ackErr = 1'b0;
      err_total = 0;
      comparisons = 0;
      repeat (12) @(posedge clock);
      reset_n <= 1'b1;
      @(posedge clock);
      chk("idleOut", 41'h0, {pinFromScan, coreFromScan, svcReq, tdoEn});
      prb_u.goIdle();
      foreach (rows[i]) begin
         pinIn <= 8'h5a ^ 8'(i);
         coreOut <= 8'hc3 ^ 8'(i);
         prb_u.scan(1'b1, 5, 34'(rows[i].op), dout);
         chk("irCapture", 41'h01, dout[4:0]);
         chk("pinFromScan", rows[i].pfs, pinFromScan);
         chk("coreFromScan", rows[i].cfs, coreFromScan);
         if (rows[i].kind == 2'h0) begin
            prb_u.scan(1'b0, 2, 34'h1, dout);
            chk("bypassPath", 41'h2, dout[1:0]);
         end else begin
            held = pinOut;
            prb_u.scan(1'b0, 8, 34'(8'ha5 ^ 8'(i)), dout);
            chk("chainCapture", (rows[i].kind == 2'h2) ? coreOut : pinIn, dout[7:0]);
            chk("chainUpdate", (rows[i].kind == 2'h3) ? held : 8'ha5 ^ 8'(i), pinOut);
         end
      end
      chipProtected <= 1'b1;
      prb_u.scan(1'b1, 5, 34'(jisd_pkg::OP_DEBUG), dout);
      chk("irProtected", 41'h11, dout[4:0]);
      prb_u.scan(1'b0, 8, 34'h57, dout);
      chk("readReq", 41'h0ab, lastReq[40:32]);
      prb_u.scan(1'b0, 34, 34'h0, dout);
      chk("readData", {RDATA, 2'b00}, dout);
      chipProtected <= 1'b0;
      ackDelay = 3000;
      ackErr = 1'b1;
      prb_u.scan(1'b1, 5, 34'(jisd_pkg::OP_MEMSVC), dout);
      chk("irPrivate", 41'h01, dout[4:0]);
      prb_u.scan(1'b0, 8, 34'h2a, dout);
      chk("writeHeld", 41'd1, 41'(reqCount));
      prb_u.scan(1'b0, 34, {32'hdeadbeef, 2'b00}, dout);
      chk("writeReq", {9'h115, 32'hdeadbeef}, lastReq);
      prb_u.scan(1'b0, 34, 34'h0, dout);
      chk("busyFlag", 41'h1, dout[0]);
      chk("busyNoReq", 41'd2, 41'(reqCount));
      repeat (3000) @(posedge clock);
      ackDelay = 5;
      ackErr = 1'b0;
      prb_u.scan(1'b0, 8, 34'h67, dout);
      chk("errorFlag", 41'h2, dout[1:0]);
      chk("phaseHeld", 41'h1b3, lastReq[40:32]);
      prb_u.scan(1'b0, 10, 34'h0, dout);
      chk("shortRead", {8'hcd, 2'b00}, dout[9:0]);
      prb_u.scan(1'b1, 5, 34'(jisd_pkg::OP_EXTEST), dout);
      prb_u.goIdle();
      chk("tmsReset", 41'h0, pinFromScan);
      prb_u.scan(1'b1, 5, 34'(jisd_pkg::OP_CLAMP), dout);
      reset_n <= 1'b0;
      repeat (4) @(posedge clock);
      reset_n <= 1'b1;
      @(posedge clock);
      chk("midReset", 41'h0, pinFromScan);
      final_report();
   end
endmodule
`default_nettype wire
